// *** pkg/racm_pkg.sv ***
// constants and types for the region attribute and cache management block
package racm_pkg;
    // ==========================================================
    // region attribute register fields
    localparam int RA_BASE_LSB   = 24;
    localparam int RA_MASK_LSB   = 16;
    localparam int RA_EN_BIT     = 15;
    localparam int RA_PRIV_LSB   = 13;
    localparam int RA_POL_LSB    = 5;
    localparam int RA_WP_BIT     = 2;
    localparam logic [31:0] RA_RD_MASK = 32'hffffe064;
    localparam logic [31:0] RA_RESET   = 32'h00000000;
    // ==========================================================
    // cache control register fields
    localparam int CC_ON_BIT     = 31;
    localparam int CC_NOINV_BIT  = 28;
    localparam int CC_FLUSH_BIT  = 24;
    localparam int CC_DPOL_LSB   = 8;
    localparam logic [31:0] CC_RESET   = 32'h00000000;
    // ==========================================================
    // directory geometry
    localparam int NUM_SETS      = 128;
    localparam int NUM_WAYS      = 4;
    localparam int NUM_LINES     = 512;
    localparam int LINE_BYTES    = 16;
    localparam int SET_W         = 7;
    localparam int WAY_W         = 2;
    localparam int PP_SET_LSB    = 4;
    localparam int PP_WAY_LSB    = 0;
    // ==========================================================
    // control register move selectors
    localparam logic [1:0] SEL_CACHE_CTRL = 2'h0;
    localparam logic [1:0] SEL_REGION_0   = 2'h1;
    localparam logic [1:0] SEL_REGION_1   = 2'h2;
    // cache policies
    localparam logic [1:0] POL_WTHRU = 2'h0;
    localparam logic [1:0] POL_COPYB = 2'h1;
    localparam logic [1:0] POL_INH_P = 2'h2;
    localparam logic [1:0] POL_INH_I = 2'h3;

    typedef enum logic [2:0] {
        RACM_IDLE  = 3'h1,
        RACM_FLUSH = 3'h2,
        RACM_PUSH  = 3'h4
    } racm_state_e;
endpackage : racm_pkg

// *** logic/racm_dir_mem.sv ***
// line state directory: valid and modified bits per set and way
`timescale 1ns/1ps
module racm_dir_mem
    import racm_pkg::*;
(
    // clock
    input  wire logic                 clk,
    // write port: one set, per-way write enables
    input  wire logic                 wr_en,
    input  wire logic [SET_W-1:0]     wr_set,
    input  wire logic [NUM_WAYS-1:0]  wr_way_mask,
    input  wire logic [1:0]           wr_state,
    // registered read port
    input  wire logic [SET_W-1:0]     rd_set,
    output logic      [2*NUM_WAYS-1:0] rd_state
);
    // no reset here: line states survive reset by design
    // ==========================================================
    // one storage lane per way, each with its own writer, so a push can
    // touch one way while an invalidate writes all four at once
    genvar g;
    generate
        for (g = 0; g < NUM_WAYS; g++) begin : g_way
            logic [1:0] lane [NUM_SETS];
            logic [1:0] rd_q;
            always_ff @(posedge clk) begin
                if (wr_en && wr_way_mask[g]) begin
                    lane[wr_set] <= wr_state;
                end
            end
            // read data from a register
            always_ff @(posedge clk) begin
                rd_q <= lane[rd_set];
            end
            assign rd_state[2*g +: 2] = rd_q;
        end
    endgenerate
endmodule : racm_dir_mem

// *** logic/racm_top.sv ***
// region attribute matcher with cache control and line push sequencing
`timescale 1ns/1ps
module racm_top
    import racm_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // control register moves from the core
    input  wire logic        ctl_wr,
    input  wire logic [1:0]  ctl_sel,
    input  wire logic [31:0] ctl_wdata,
    output logic      [31:0] ctl_rdata,
    // access lookup
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    input  wire logic        acc_super,
    input  wire logic        acc_write,
    output logic      [1:0]  cache_policy,
    output logic             acc_write_fault,
    output logic             acc_stall,
    output logic             cache_active,
    // line push request
    input  wire logic        push_valid,
    input  wire logic [31:0] line_push_pointer,
    output logic             push_ready,
    output logic             wb_valid,
    output logic [SET_W-1:0] wb_set,
    output logic [WAY_W-1:0] wb_way,
    output logic             wb_dirty
);
    // ==========================================================
    // overview
    // lookups: the upper address byte meets both region registers every
    // cycle; policy and write fault are registered, so they answer one
    // cycle after the address is presented
    // moves: a write lands on the edge that sees the strobe; reads are
    // registered too and follow the selector by one cycle
    // invalidate-all: the request bit is set by a move and cleared by
    // the sequencer after the last set; lookups stall for the whole
    // pass, about 130 cycles, and pushes are held off until it ends
    // push: two cycles from the taken edge to the write-back pulse;
    // the extra cycle waits out the registered directory read, traded
    // against a combinational read port that would not map to memory
    // reset: control and region registers clear, the directory does not;
    // software must invalidate before trusting line states at power-up
    // cache enable is only reported; no path here depends on it, so a
    // disabled cache still pushes and invalidates
    // hazard: a lookup that overlaps both regions always takes region
    // zero, so software places the narrower region there
    typedef struct packed {
        logic [31:0]      region_attr_zero;
        logic [31:0]      region_attr_one;
        logic [31:0]      cache_ctrl;
        racm_state_e      state;
        logic [SET_W-1:0] set_idx;
        logic [WAY_W-1:0] way_idx;
        logic             rd_wait;
        logic             wb_valid;
        logic             wb_dirty;
        logic [1:0]       policy;
        logic             wfault;
        logic [31:0]      rdata;
    } racm_s;

    racm_s q_reg;
    racm_s q_next;

    logic                  dir_wr_en;
    logic [NUM_WAYS-1:0]   dir_way_mask;
    logic [1:0]            dir_wr_state;
    logic [SET_W-1:0]      dir_rd_set;
    logic [2*NUM_WAYS-1:0] dir_rd_state;

    // ==========================================================
    // region matching
    // one decode used by both registers keeps them identical
    function automatic logic region_hit(input logic [31:0] ra,
                                        input logic [7:0]  abyte,
                                        input logic        sup);
        logic en;
        logic priv_ok;
        logic base_ok;
        en      = ra[RA_EN_BIT];
        priv_ok = ra[RA_PRIV_LSB+1] |
                  (ra[RA_PRIV_LSB] == sup);
        base_ok = ((ra[RA_BASE_LSB +: 8] ^ abyte) &
                   ~ra[RA_MASK_LSB +: 8]) == 8'h00;
        return en & priv_ok & base_ok;
    endfunction : region_hit

    logic hit0;
    logic hit1;
    assign hit0 = region_hit(q_reg.region_attr_zero, acc_addr[31:24],
                             acc_super);
    assign hit1 = region_hit(q_reg.region_attr_one, acc_addr[31:24],
                             acc_super);

    // ==========================================================
    // field decoding shared by both region registers
    // pulling each field out in one place keeps the two registers from
    // drifting apart if a field ever moves
    function automatic logic [1:0] region_policy(input logic [31:0] ra);
        return ra[RA_POL_LSB +: 2];
    endfunction : region_policy

    // write-protect flag; only writes are refused, reads pass
    function automatic logic region_wprot(input logic [31:0] ra);
        return ra[RA_WP_BIT];
    endfunction : region_wprot

    // value kept on a region move; the fixed-zero bits are never stored,
    // so a readback needs no masking of its own
    function automatic logic [31:0] region_store(input logic [31:0] d);
        return d & RA_RD_MASK;
    endfunction : region_store

    // ==========================================================
    // push operand decoding
    // the operand is a directory index, never a memory address; line
    // field bits 3-2 are ignored since only four ways exist
    function automatic logic [SET_W-1:0] push_set(input logic [31:0] ptr);
        return ptr[PP_SET_LSB +: SET_W];
    endfunction : push_set

    function automatic logic [WAY_W-1:0] push_way(input logic [31:0] ptr);
        return ptr[PP_WAY_LSB +: WAY_W];
    endfunction : push_way

    // ==========================================================
    // line state helpers; bit 1 valid, bit 0 modified
    // only a valid and modified line has anything to write back
    function automatic logic line_dirty(input logic [1:0] st);
        return st[1] & st[0];
    endfunction : line_dirty

    // state left by a push: invalid, or valid bit kept and modified bit cleared
    // when the keep-valid control bit is set
    function automatic logic [1:0] push_after(input logic [1:0] st,
                                              input logic       keep);
        return keep ? {st[1], 1'b0} : 2'h0;
    endfunction : push_after

    // write lane of a single way
    function automatic logic [NUM_WAYS-1:0] way_lane(
        input logic [WAY_W-1:0] w);
        return NUM_WAYS'(1) << w;
    endfunction : way_lane

    // true on the last set of an invalidate pass
    function automatic logic last_set(input logic [SET_W-1:0] s);
        return s == SET_W'(NUM_SETS - 1);
    endfunction : last_set

    // ==========================================================
    // move decode, one strobe per register; selector 3 writes nothing
    logic mv_cc;
    logic mv_r0;
    logic mv_r1;
    assign mv_cc = ctl_wr & (ctl_sel == SEL_CACHE_CTRL);
    assign mv_r0 = ctl_wr & (ctl_sel == SEL_REGION_0);
    assign mv_r1 = ctl_wr & (ctl_sel == SEL_REGION_1);

    // ==========================================================
    // directory
    racm_dir_mem u_dir (
        .clk         (clk),
        .wr_en       (dir_wr_en),
        .wr_set      (q_reg.set_idx),
        .wr_way_mask (dir_way_mask),
        .wr_state    (dir_wr_state),
        .rd_set      (dir_rd_set),
        .rd_state    (dir_rd_state)
    );

    // ==========================================================
    // next state
    always_comb begin
        logic [1:0] pol;
        logic       wp;
        logic [1:0] line_st;
        pol     = 2'h0;
        wp      = 1'b0;
        line_st = 2'h0;
        q_next  = q_reg;
        dir_wr_en    = 1'b0;
        dir_way_mask = '0;
        dir_wr_state = 2'h0;
        dir_rd_set   = q_reg.set_idx;
        q_next.wb_valid = 1'b0;

        // attribute selection, register zero first on overlap
        if (hit0) begin
            pol = region_policy(q_reg.region_attr_zero);
            wp  = region_wprot(q_reg.region_attr_zero);
        end else if (hit1) begin
            pol = region_policy(q_reg.region_attr_one);
            wp  = region_wprot(q_reg.region_attr_one);
        end else begin
            pol = q_reg.cache_ctrl[CC_DPOL_LSB +: 2];
            wp  = 1'b0;
        end
        q_next.policy = pol;
        q_next.wfault = acc_valid & acc_write & wp;

        // control register moves, full longwords only
        if (mv_r0) begin
            q_next.region_attr_zero = region_store(ctl_wdata);
        end
        if (mv_r1) begin
            q_next.region_attr_one = region_store(ctl_wdata);
        end
        if (mv_cc) begin
            q_next.cache_ctrl = ctl_wdata;
        end
        case (ctl_sel)
            SEL_REGION_0:   q_next.rdata = q_reg.region_attr_zero;
            SEL_REGION_1:   q_next.rdata = q_reg.region_attr_one;
            SEL_CACHE_CTRL: q_next.rdata = q_reg.cache_ctrl;
            default:        q_next.rdata = 32'h00000000;
        endcase

        // sequencer; the enable bit plays no part here
        case (q_reg.state)
            RACM_IDLE: begin
                if (q_reg.cache_ctrl[CC_FLUSH_BIT]) begin
                    q_next.state   = RACM_FLUSH;
                    q_next.set_idx = '0;
                end else if (push_valid) begin
                    // operand indexes the directory directly
                    q_next.set_idx = push_set(line_push_pointer);
                    q_next.way_idx = push_way(line_push_pointer);
                    // read starts now so the state is ready in two cycles
                    dir_rd_set     = push_set(line_push_pointer);
                    q_next.rd_wait = 1'b1;
                    q_next.state   = RACM_PUSH;
                end
            end
            RACM_FLUSH: begin
                // one set per cycle, all four ways at once
                dir_wr_en    = 1'b1;
                dir_way_mask = '1;
                dir_wr_state = 2'h0;
                q_next.set_idx = q_reg.set_idx + 1'b1;
                if (last_set(q_reg.set_idx)) begin
                    // a control move in this cycle wins over the
                    // self-clear, so a request made on the last set is not lost
                    if (!mv_cc) begin
                        q_next.cache_ctrl[CC_FLUSH_BIT] = 1'b0;
                    end
                    q_next.state = RACM_IDLE;
                end
            end
            RACM_PUSH: begin
                if (q_reg.rd_wait) begin
                    q_next.rd_wait = 1'b0;
                end else begin
                    line_st = dir_rd_state[2*q_reg.way_idx +: 2];
                    // bit1 valid, bit0 modified
                    q_next.wb_valid = line_dirty(line_st);
                    q_next.wb_dirty = line_dirty(line_st);
                    dir_wr_en    = 1'b1;
                    dir_way_mask = way_lane(q_reg.way_idx);
                    dir_wr_state = push_after(line_st,
                        q_reg.cache_ctrl[CC_NOINV_BIT]);
                    q_next.state = RACM_IDLE;
                end
            end
            default: q_next.state = RACM_IDLE;
        endcase

        // reset last, so it overrides every register update above; directory writes are not gated
        if (srst) begin
            q_next = '0;
            q_next.region_attr_zero = RA_RESET;
            q_next.region_attr_one  = RA_RESET;
            q_next.cache_ctrl       = CC_RESET;
            q_next.state            = RACM_IDLE;
        end
    end

    // ==========================================================
    // state register; directory contents are not reset
    always_ff @(posedge clk) begin
        q_reg <= q_next;
    end

    // ==========================================================
    // outputs
    assign ctl_rdata       = q_reg.rdata;
    assign cache_policy    = q_reg.policy;
    assign acc_write_fault = q_reg.wfault;
    // stall later accesses while the invalidate walks the sets
    assign acc_stall       = (q_reg.state == RACM_FLUSH) |
                             q_reg.cache_ctrl[CC_FLUSH_BIT];
    assign cache_active    = q_reg.cache_ctrl[CC_ON_BIT];
    assign push_ready      = (q_reg.state == RACM_IDLE) &
                             ~q_reg.cache_ctrl[CC_FLUSH_BIT];
    assign wb_valid        = q_reg.wb_valid;
    assign wb_set          = q_reg.set_idx;
    assign wb_way          = q_reg.way_idx;
    assign wb_dirty        = q_reg.wb_dirty;
endmodule : racm_top

// *** testbench/racm_properties.sv ***
// port assertions for the region attribute and cache management block
`timescale 1ns/1ps
module racm_properties
    import racm_pkg::*;
(
    // clock, reset and control moves
    input wire logic             clk, srst, ctl_wr,
    input wire logic [1:0]       ctl_sel,
    input wire logic [31:0]      ctl_wdata, ctl_rdata, line_push_pointer,
    // lookup and push results
    input wire logic             acc_valid, acc_write, acc_write_fault,
    input wire logic             acc_stall, push_valid, push_ready, wb_valid,
    input wire logic [SET_W-1:0] wb_set,
    input wire logic [WAY_W-1:0] wb_way
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [8:0] last_reg; // index taken with the last push
    // ==========================================================
    // capture the pushed index so late results can be matched
    always_ff @(posedge clk) begin
        if (push_valid && push_ready)
            last_reg <= {line_push_pointer[10:4], line_push_pointer[1:0]};
    end
    sequence s_flush_go;
        ctl_wr && ctl_sel == SEL_CACHE_CTRL && ctl_wdata[CC_FLUSH_BIT]
            && !acc_stall && push_ready;
    endsequence
    sequence s_push_take;
        push_valid && push_ready;
    endsequence
    // ==========================================================
    // assertions
    chk_reg_readback: assert property (ctl_wr && ctl_sel == SEL_REGION_0
        ##1 ctl_sel == SEL_REGION_0 && !ctl_wr
        |=> ctl_rdata == ($past(ctl_wdata, 2) & RA_RD_MASK))
        else $error("region readback differs from written longword");
    chk_rsvd_zero: assert property (ctl_sel != SEL_CACHE_CTRL
        |=> (ctl_rdata & ~RA_RD_MASK) == 32'h0)
        else $error("reserved region bits read nonzero");
    chk_reset_clear: assert property ($fell(srst)
        |-> !acc_stall && push_ready && !wb_valid)
        else $error("state not cleared by reset");
    chk_flush_stall: assert property (s_flush_go |=> acc_stall [*8])
        else $error("accesses not stalled during flush");
    chk_flush_ends: assert property (s_flush_go |-> ##[120:140] !acc_stall)
        else $error("flush did not finish in time");
    chk_flush_exact: assert property (s_flush_go
        |-> ##129 acc_stall ##1 !acc_stall)
        else $error("flush length differs from one pass over all sets");
    chk_stall_blocks: assert property (acc_stall |-> !push_ready)
        else $error("push accepted during flush");
    chk_push_busy: assert property (s_push_take |=> !push_ready ##1 !push_ready)
        else $error("push ready too early");
    chk_push_index: assert property (s_push_take
        |=> ##[1:3] {wb_set, wb_way} == last_reg)
        else $error("pushed line index wrong");
    chk_fault_cause: assert property (!(acc_valid && acc_write)
        |=> !acc_write_fault)
        else $error("write fault without a write access");
    chk_wb_pulse: assert property (wb_valid |=> !wb_valid)
        else $error("write back flag held too long");
endmodule : racm_properties

bind racm_top racm_properties chk_u (.clk(clk), .srst(srst),
    .ctl_wr(ctl_wr), .ctl_sel(ctl_sel), .ctl_wdata(ctl_wdata),
    .ctl_rdata(ctl_rdata), .line_push_pointer(line_push_pointer),
    .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_write_fault(acc_write_fault), .acc_stall(acc_stall),
    .push_valid(push_valid), .push_ready(push_ready),
    .wb_valid(wb_valid), .wb_set(wb_set), .wb_way(wb_way));

// *** testbench/racm_core_model.sv ***
// core side model issuing line push requests
`timescale 1ns/1ps
module racm_core_model
    import racm_pkg::*;
(
    // handshake with the block
    input  wire logic        clk,
    input  wire logic        push_ready,
    output logic             push_valid,
    output logic [31:0]      line_push_pointer
);
    initial begin
        push_valid = 1'b0;
        line_push_pointer = 32'h0;
    end
    // ==========================================================
    // one push; gap models a slow core before the request
    task automatic push_line(input logic [SET_W-1:0] s,
                             input logic [WAY_W-1:0] w, input int gap);
        repeat (gap) @(negedge clk);
        line_push_pointer = {21'h0, s, 2'h0, w};
        push_valid = 1'b1;
        // ready comes from a register, so seeing it high at a falling
        // edge means the next rising edge takes the request
        while (!push_ready) @(negedge clk);
        @(negedge clk);
        push_valid = 1'b0;
        // released operand is not left looking valid
        line_push_pointer = ~line_push_pointer;
    endtask : push_line
endmodule : racm_core_model

// *** testbench/testbench.sv ***
// self-checking bench for the region attribute and cache management block
`timescale 1ns/1ps
module testbench
    import racm_pkg::*;
;
    logic             clk, srst, ctl_wr, acc_valid, acc_super, acc_write;
    logic             push_valid, push_ready, acc_write_fault, acc_stall;
    logic             cache_active, wb_valid, wb_dirty;
    logic [1:0]       ctl_sel, cache_policy;
    logic [31:0]      ctl_wdata, ctl_rdata, acc_addr, line_push_pointer;
    logic [31:0]      r0, r1, cc, v;
    logic [SET_W-1:0] wb_set;
    logic [WAY_W-1:0] wb_way;
    int               n_errors = 0, total_checks = 0, seed = 72971, k;
    racm_top dut_u (.clk(clk), .srst(srst), .ctl_wr(ctl_wr),
        .ctl_sel(ctl_sel), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_super(acc_super),
        .acc_write(acc_write), .cache_policy(cache_policy),
        .acc_write_fault(acc_write_fault), .acc_stall(acc_stall),
        .cache_active(cache_active), .push_valid(push_valid),
        .line_push_pointer(line_push_pointer), .push_ready(push_ready),
        .wb_valid(wb_valid), .wb_set(wb_set), .wb_way(wb_way),
        .wb_dirty(wb_dirty));
    racm_core_model core_u (.clk(clk), .push_ready(push_ready),
        .push_valid(push_valid), .line_push_pointer(line_push_pointer));
    // ==========================================================
    // expectations
    function automatic logic hit(input logic [31:0] r, input logic [7:0] a,
                                 input logic s);
        return r[RA_EN_BIT] && (r[RA_PRIV_LSB+1] || r[RA_PRIV_LSB] == s)
            && ((r[31:24] ^ a) & ~r[23:16]) == 8'h0;
    endfunction : hit
    function automatic logic [2:0] exp_acc(input logic [31:0] a,
                                           input logic s, input logic w);
        if (hit(r0, a[31:24], s)) return {w & r0[RA_WP_BIT], r0[6:5]};
        if (hit(r1, a[31:24], s)) return {w & r1[RA_WP_BIT], r1[6:5]};
        return {1'b0, cc[9:8]};
    endfunction : exp_acc
    // ==========================================================
    // checks and bus tasks, entered at a falling edge
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [1:0] sel, input logic [31:0] d);
        ctl_sel = sel;
        ctl_wdata = d;
        ctl_wr = 1'b1;
        if (sel == SEL_REGION_0) r0 = d & RA_RD_MASK;
        if (sel == SEL_REGION_1) r1 = d & RA_RD_MASK;
        if (sel == SEL_CACHE_CTRL) cc = d;
        @(negedge clk);
        ctl_wr = 1'b0;
        ctl_wdata = ~d;
        // let an edge pass so a following move raises a fresh strobe
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [1:0] sel, input logic [31:0] exp);
        ctl_sel = sel;
        @(negedge clk);
        check(ctl_rdata, exp);
    endtask : rd
    task automatic acc(input logic [31:0] a, input logic s, input logic w);
        acc_valid = 1'b1;
        acc_addr = a;
        acc_super = s;
        acc_write = w;
        @(negedge clk);
        check(32'({acc_write_fault, cache_policy}), 32'(exp_acc(a, s, w)));
        acc_valid = 1'b0;
        @(negedge clk);
    endtask : acc
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // ==========================================================
    // clock and watchdog; whole run needs under 2000 cycles
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
    // ==========================================================
    // main sequence
    initial begin
        {ctl_wr, ctl_sel, ctl_wdata, acc_valid, acc_addr} = '0;
        {acc_super, acc_write, r0, r1, cc} = '0;
        srst = 1'b1;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        wr(2'h3, 32'hffff_ffff);
        rd(SEL_CACHE_CTRL, 32'h0);
        rd(2'h3, 32'h0);
        wr(SEL_CACHE_CTRL, 32'h0100_0000);
        for (k = 0; acc_stall && k < 200; k++) @(negedge clk);
        check(32'(k >= 120 && k <= 140), 32'h1);
        rd(SEL_CACHE_CTRL, 32'h0);
        // push every way, both cache states, fast and slow core
        for (k = 0; k < 8; k++) begin
            wr(SEL_CACHE_CTRL, k[0] ? 32'h9000_0000 : 32'h0);
            check(32'(cache_active), 32'(k[0]));
            core_u.push_line(k[0] ? 7'h7f : 7'(k * 9), 2'(k), k % 3);
            repeat (4) @(negedge clk);
            check(32'({wb_valid, wb_dirty, wb_set, wb_way}),
                  32'({2'b00, k[0] ? 7'h7f : 7'(k * 9), 2'(k)}));
        end
        // reset in mid-run: control cleared, cache switched off
        srst = 1'b1;
        {r0, r1, cc} = '0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        check(32'(cache_active), 32'h0);
        rd(SEL_CACHE_CTRL, 32'h0);
        // overlap then disabled priority region
        wr(SEL_REGION_0, 32'h40ff_c020);
        wr(SEL_REGION_1, 32'h4000_c044);
        acc(32'h4000_0000, 1'b0, 1'b1);
        wr(SEL_REGION_0, 32'h40ff_4020);
        acc(32'h4012_3450, 1'b1, 1'b1);
        for (k = 0; k < 300; k++) begin
            if (k % 20 == 0) begin
                wr(SEL_REGION_0, $random(seed));
                wr(SEL_REGION_1, $random(seed));
                wr(SEL_CACHE_CTRL, $random(seed) & 32'h8000_0300);
                rd(SEL_REGION_1, r1);
            end
            v = $random(seed);
            if (v[0]) v[31:24] = r0[31:24] ^ (v[23:16] & r0[23:16]);
            acc(v, v[1], v[2]);
        end
        print_verdict();
    end
endmodule : testbench
